/* File: verilog/t2rt_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "t2rt_regs.svh"

module t2rt_top
  import t2rt_pkg::*;
(
  input  wire logic       i_core_clk,            // cpu system clock, 50 MHz
  input  wire logic       i_nrst,                // synchronous reset, active low
  input  wire logic       i_instr_valid,         // an instruction executes this cycle
  input  wire logic [9:0] i_instr,               // the instruction word
  input  wire logic [3:0] i_acc,                 // current accumulator a
  input  wire logic [3:0] i_reg_b,               // current register b
  input  wire logic       i_timer_cnt_we,        // timer logic updates the count
  input  wire logic [7:0] i_timer_cnt_wdata,     // count value from timer logic
  output logic      [7:0] o_timer_cnt,           // timer 2 count
  output logic      [7:0] o_timer_low_reload_reg,  // low reload word
  output logic      [7:0] o_timer_high_reload_reg, // high reload word
  output logic            o_acc_we,              // accumulator write strobe
  output logic      [3:0] o_acc_wdata,           // accumulator write value
  output logic            o_carry_flag_we,       // carry flag write strobe
  output logic            o_skip_next,           // skip request for next word
  output logic            o_done                 // one of our four executed
);

  // ---------------------------------------------------------------------------
  // decoder
  // ---------------------------------------------------------------------------
  t2rt_dec_if dec_bus ();                        // executor to decoder link

  assign dec_bus.valid  = i_instr_valid;
  assign dec_bus.opcode = i_instr;

  t2rt_decode u_decode (
    .bus (dec_bus.dec)
  );

  t2rt_cmd_t cmd;                                // decoded command this cycle
  assign cmd = dec_bus.cmd;

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  t2rt_byte_t   timer_q,   timer_d;              // timer 2 count
  t2rt_byte_t   low_q,     low_d;                // low reload word
  t2rt_byte_t   high_q,    high_d;               // high reload word
  logic         acc_we_q,  acc_we_d;             // accumulator strobe
  t2rt_nibble_t acc_q,     acc_d;                // accumulator data
  logic         carry_q,   carry_d;              // carry write strobe
  logic         skip_q,    skip_d;               // skip request
  logic         done_q,    done_d;               // executed marker
  t2rt_byte_t   ba_word;                         // b in the high, a in the low

  assign ba_word = {i_reg_b, i_acc};

  // ---------------------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------------------
  // every command finishes in a single edge, so there is no sequencer;
  // an instruction write beats a same-cycle count update from the timer,
  // because software that reloads the timer expects its value to stick
  always_comb begin
    timer_d  = timer_q;
    low_d    = low_q;
    high_d   = high_q;
    acc_we_d = 1'b0;                             // strobe lasts one cycle
    acc_d    = acc_q;
    carry_d  = 1'b0;
    skip_d   = 1'b0;
    done_d   = 1'b0;
    if (i_timer_cnt_we) begin
      timer_d = i_timer_cnt_wdata;               // counting done elsewhere
    end
    case (cmd)
      T2RT_CMD_LOAD_TIMER_AND_LOW_RELOAD: begin
        timer_d[`T2RT_HI_MSB:`T2RT_HI_LSB] = i_reg_b;
        timer_d[`T2RT_LO_MSB:`T2RT_LO_LSB] = i_acc;
        low_d                              = ba_word;
        done_d                             = 1'b1;
      end
      T2RT_CMD_LOAD_HIGH_RELOAD: begin
        high_d = ba_word;
        done_d = 1'b1;
      end
      T2RT_CMD_COPY_LOW_RELOAD_TO_TIMER: begin
        timer_d = low_q;
        done_d  = 1'b1;
      end
      T2RT_CMD_COPY_B_TO_ACC: begin
        acc_we_d = 1'b1;
        acc_d    = i_reg_b;
        done_d   = 1'b1;
      end
      default: begin
        done_d = 1'b0;                           // not one of ours
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      timer_q  <= `T2RT_TIMER_RST;
      low_q    <= `T2RT_RELOAD_RST;
      high_q   <= `T2RT_RELOAD_RST;
      acc_we_q <= 1'b0;
      acc_q    <= `T2RT_NIBBLE_RST;
      carry_q  <= 1'b0;
      skip_q   <= 1'b0;
      done_q   <= 1'b0;
    end else begin
      timer_q  <= timer_d;
      low_q    <= low_d;
      high_q   <= high_d;
      acc_we_q <= acc_we_d;
      acc_q    <= acc_d;
      carry_q  <= carry_d;
      skip_q   <= skip_d;
      done_q   <= done_d;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs, all straight from flops
  // ---------------------------------------------------------------------------
  assign o_timer_cnt             = timer_q;
  assign o_timer_low_reload_reg  = low_q;
  assign o_timer_high_reload_reg = high_q;
  assign o_acc_we                = acc_we_q;
  assign o_acc_wdata             = acc_q;
  assign o_carry_flag_we         = carry_q;
  assign o_skip_next             = skip_q;
  assign o_done                  = done_q;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  // combined load lands both words one edge later
  a_combined_load_words: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    (cmd == T2RT_CMD_LOAD_TIMER_AND_LOW_RELOAD)
    |=> (o_timer_cnt == $past(ba_word)) && (o_timer_low_reload_reg == $past(ba_word))
  ) else $error("combined load did not write timer and low reload");

  // combined load leaves the high word alone
  a_combined_keeps_high: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    (cmd == T2RT_CMD_LOAD_TIMER_AND_LOW_RELOAD) |=> $stable(o_timer_high_reload_reg)
  ) else $error("combined load disturbed the high reload word");

  // high load touches only the high word
  a_high_load_only: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    (cmd == T2RT_CMD_LOAD_HIGH_RELOAD) && !i_timer_cnt_we
    |=> (o_timer_high_reload_reg == $past(ba_word)) && $stable(o_timer_cnt)
        && $stable(o_timer_low_reload_reg)
  ) else $error("high reload load wrong or touched other words");

  // copy moves the whole low word into the count
  a_copy_low_timer: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    (cmd == T2RT_CMD_COPY_LOW_RELOAD_TO_TIMER)
    |=> (o_timer_cnt == $past(o_timer_low_reload_reg)) && $stable(o_timer_low_reload_reg)
  ) else $error("low reload word not copied into timer");

  // accumulator gets b, as a single strobe
  a_b_to_acc_write: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    (cmd == T2RT_CMD_COPY_B_TO_ACC)
    |=> o_acc_we && (o_acc_wdata == $past(i_reg_b))
  ) else $error("accumulator not loaded from b");

  // no strobe without the command
  a_acc_strobe_cause: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    o_acc_we |-> ($past(cmd) == T2RT_CMD_COPY_B_TO_ACC)
  ) else $error("accumulator strobe without its instruction");

  // carry and skip stay quiet whatever runs
  a_no_carry_skip: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    !o_carry_flag_we && !o_skip_next
  ) else $error("carry or skip raised by a transfer");

  // done follows each of our four opcodes, one edge later
  a_done_from_opcode: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    i_instr_valid && ((i_instr == `T2RT_OP_LOAD_TIMER_AND_LOW_RELOAD)
      || (i_instr == `T2RT_OP_LOAD_HIGH_RELOAD)
      || (i_instr == `T2RT_OP_COPY_LOW_RELOAD_TO_TIMER)
      || (i_instr == `T2RT_OP_COPY_B_TO_ACC)) |=> o_done
  ) else $error("recognised opcode did not complete in one cycle");

  // a cycle with no valid word never completes
  a_done_needs_valid: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    !i_instr_valid |=> !o_done
  ) else $error("completion without an instruction");

  // a valid word that is not one of ours moves nothing and raises nothing;
  // compared against the raw word so a decoder alias cannot hide here
  a_foreign_word_idle: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    i_instr_valid && !i_timer_cnt_we
      && (i_instr != `T2RT_OP_LOAD_TIMER_AND_LOW_RELOAD)
      && (i_instr != `T2RT_OP_LOAD_HIGH_RELOAD)
      && (i_instr != `T2RT_OP_COPY_LOW_RELOAD_TO_TIMER)
      && (i_instr != `T2RT_OP_COPY_B_TO_ACC)
    |=> !o_done && !o_acc_we && $stable(o_timer_cnt)
        && $stable(o_timer_low_reload_reg) && $stable(o_timer_high_reload_reg)
  ) else $error("foreign instruction word changed block state");

  // copying b to the accumulator leaves every timer word where it was
  a_b_to_acc_keeps_words: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    (cmd == T2RT_CMD_COPY_B_TO_ACC) && !i_timer_cnt_we
    |=> $stable(o_timer_cnt) && $stable(o_timer_low_reload_reg)
        && $stable(o_timer_high_reload_reg)
  ) else $error("b to accumulator copy disturbed a timer word");

endmodule : t2rt_top

`default_nettype wire

/* File: include/t2rt_regs.svh */
`ifndef T2RT_REGS_SVH
`define T2RT_REGS_SVH

// -----------------------------------------------------------------------------
// instruction opcodes, 10-bit words
// -----------------------------------------------------------------------------
`define T2RT_OP_LOAD_TIMER_AND_LOW_RELOAD 10'h231
`define T2RT_OP_LOAD_HIGH_RELOAD          10'h294
`define T2RT_OP_COPY_LOW_RELOAD_TO_TIMER  10'h295
`define T2RT_OP_COPY_B_TO_ACC             10'h01E

// -----------------------------------------------------------------------------
// field positions inside the 8-bit timer words
// -----------------------------------------------------------------------------
`define T2RT_HI_MSB 7
`define T2RT_HI_LSB 4
`define T2RT_LO_MSB 3
`define T2RT_LO_LSB 0

// -----------------------------------------------------------------------------
// reset values and timing
// -----------------------------------------------------------------------------
`define T2RT_TIMER_RST       8'h00
`define T2RT_RELOAD_RST      8'h00
`define T2RT_NIBBLE_RST      4'h0
`define T2RT_EXEC_CYCLES     1

`endif

/* File: include/t2rt_pkg.sv */
// -----------------------------------------------------------------------------
// shared types
// -----------------------------------------------------------------------------
package t2rt_pkg;

  typedef logic [9:0] t2rt_opcode_t;   // one instruction word
  typedef logic [3:0] t2rt_nibble_t;   // accumulator or register b
  typedef logic [7:0] t2rt_byte_t;     // timer count or reload word

  // decoded command of the current instruction word
  typedef enum logic [2:0] {
    T2RT_CMD_NONE,
    T2RT_CMD_LOAD_TIMER_AND_LOW_RELOAD,
    T2RT_CMD_LOAD_HIGH_RELOAD,
    T2RT_CMD_COPY_LOW_RELOAD_TO_TIMER,
    T2RT_CMD_COPY_B_TO_ACC
  } t2rt_cmd_t;

endpackage : t2rt_pkg

/* File: include/t2rt_dec_if.sv */
`timescale 1ns/1ns
`default_nettype none

// -----------------------------------------------------------------------------
// link between the executor and its opcode decoder
// -----------------------------------------------------------------------------
interface t2rt_dec_if;
  import t2rt_pkg::*;

  logic         valid;   // instruction word present this cycle
  t2rt_opcode_t opcode;  // the word itself
  t2rt_cmd_t    cmd;     // decoded command, none when not ours

  modport dec (input valid, input opcode, output cmd);
  modport exe (output valid, output opcode, input cmd);
endinterface : t2rt_dec_if

`default_nettype wire

/* File: verilog/t2rt_decode.sv */
`timescale 1ns/1ns
`default_nettype none
`include "t2rt_regs.svh"

// -----------------------------------------------------------------------------
// opcode decoder: exact match on all ten bits
// -----------------------------------------------------------------------------
module t2rt_decode
  import t2rt_pkg::*;
(
  t2rt_dec_if.dec bus    // opcode in, command out
);

  // full-width compare so no partial pattern aliases another instruction
  always_comb begin
    bus.cmd = T2RT_CMD_NONE;
    if (bus.valid) begin
      case (bus.opcode)
        `T2RT_OP_LOAD_TIMER_AND_LOW_RELOAD: begin
          bus.cmd = T2RT_CMD_LOAD_TIMER_AND_LOW_RELOAD;
        end
        `T2RT_OP_LOAD_HIGH_RELOAD: begin
          bus.cmd = T2RT_CMD_LOAD_HIGH_RELOAD;
        end
        `T2RT_OP_COPY_LOW_RELOAD_TO_TIMER: begin
          bus.cmd = T2RT_CMD_COPY_LOW_RELOAD_TO_TIMER;
        end
        `T2RT_OP_COPY_B_TO_ACC: begin
          bus.cmd = T2RT_CMD_COPY_B_TO_ACC;
        end
        default: begin
          bus.cmd = T2RT_CMD_NONE;   // some other instruction
        end
      endcase
    end
  end

endmodule : t2rt_decode

`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "t2rt_regs.svh"

// -----------------------------------------------------------------------------
// compare helper: counts every compare, reports a mismatch at once
// -----------------------------------------------------------------------------
`define T2RT_CHK(got, exp) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, got, exp); \
  end \
end

module tb
  import t2rt_pkg::*;
;
  logic         i_core_clk;                // 50 MHz cpu clock
  logic         i_nrst;                    // sync reset, active low
  logic         i_instr_valid;             // instruction present
  t2rt_opcode_t i_instr;                   // instruction word
  t2rt_nibble_t i_acc;                     // accumulator a
  t2rt_nibble_t i_reg_b;                   // register b
  logic         i_timer_cnt_we;            // external count write
  t2rt_byte_t   i_timer_cnt_wdata;         // external count value
  t2rt_byte_t   o_timer_cnt;               // timer count
  t2rt_byte_t   o_timer_low_reload_reg;    // low reload word
  t2rt_byte_t   o_timer_high_reload_reg;   // high reload word
  logic         o_acc_we;                  // accumulator strobe
  t2rt_nibble_t o_acc_wdata;               // accumulator value
  logic         o_carry_flag_we;           // carry strobe, never set
  logic         o_skip_next;               // skip request, never set
  logic         o_done;                    // executed pulse
  // expected state, kept by the bench alone
  t2rt_byte_t   e_tmr, e_lo, e_hi;         // expected words
  t2rt_nibble_t e_awd;                     // expected accumulator value
  logic         e_awe, e_done;             // expected pulses
  int           num_errors, n_compared;    // counters
  integer       seed;                      // fixed random seed
  t2rt_opcode_t ops [4];                   // our four opcodes

  t2rt_top dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .i_acc(i_acc), .i_reg_b(i_reg_b), .i_timer_cnt_we(i_timer_cnt_we),
    .i_timer_cnt_wdata(i_timer_cnt_wdata), .o_timer_cnt(o_timer_cnt),
    .o_timer_low_reload_reg(o_timer_low_reload_reg),
    .o_timer_high_reload_reg(o_timer_high_reload_reg), .o_acc_we(o_acc_we),
    .o_acc_wdata(o_acc_wdata), .o_carry_flag_we(o_carry_flag_we),
    .o_skip_next(o_skip_next), .o_done(o_done));

  // -----------------------------------------------------------------------------
  // clock
  // -----------------------------------------------------------------------------
  always #10 i_core_clk = ~i_core_clk;

  // -----------------------------------------------------------------------------
  // reference: expected state after the edge that samples these inputs
  // -----------------------------------------------------------------------------
  function automatic void predict(input logic rst_n, input logic v, input t2rt_opcode_t op,
                                  input t2rt_nibble_t a, input t2rt_nibble_t b,
                                  input logic we, input t2rt_byte_t wd);
    if (!rst_n) begin
      // reset clears every word and strobe
      {e_tmr, e_lo, e_hi, e_awd, e_awe, e_done} = '0;
    end else begin
      e_awe = 1'b0;
      e_done = 1'b0;
      // external write first, so an instruction at the same edge overrides it
      if (we) e_tmr = wd;
      if (v) begin
        case (op)
          `T2RT_OP_LOAD_TIMER_AND_LOW_RELOAD: begin
            e_tmr = {b, a};
            e_lo = {b, a};
            e_done = 1'b1;
          end
          `T2RT_OP_LOAD_HIGH_RELOAD: begin
            e_hi = {b, a};
            e_done = 1'b1;
          end
          `T2RT_OP_COPY_LOW_RELOAD_TO_TIMER: begin
            e_tmr = e_lo;
            e_done = 1'b1;
          end
          `T2RT_OP_COPY_B_TO_ACC: begin
            e_awe = 1'b1;
            e_awd = b;
            e_done = 1'b1;
          end
          default: ;  // not ours: nothing happens
        endcase
      end
    end
  endfunction : predict

  // -----------------------------------------------------------------------------
  // one cycle: drive 2 ns after our sample point, predict, compare after the edge
  // -----------------------------------------------------------------------------
  task automatic cyc(input logic v, input t2rt_opcode_t op, input t2rt_nibble_t a,
                     input t2rt_nibble_t b, input logic we, input t2rt_byte_t wd);
    #2;
    i_instr_valid = v;
    i_instr = op;
    i_acc = a;
    i_reg_b = b;
    i_timer_cnt_we = we;
    i_timer_cnt_wdata = wd;
    predict(i_nrst, v, op, a, b, we, wd);
    @(posedge i_core_clk);
    #1;
    `T2RT_CHK(o_timer_cnt, e_tmr)
    `T2RT_CHK(o_timer_low_reload_reg, e_lo)
    `T2RT_CHK(o_timer_high_reload_reg, e_hi)
    `T2RT_CHK({o_acc_we, o_acc_wdata}, {e_awe, e_awd})
    `T2RT_CHK({o_carry_flag_we, o_skip_next, o_done}, {2'b00, e_done})
  endtask : cyc

  // one random cycle; opcodes favoured so every command appears often
  task automatic rnd_cyc();
    int unsigned k;
    t2rt_opcode_t op;
    k = {$random(seed)} % 6;
    op = (k < 4) ? ops[k] : 10'($random(seed));
    cyc(1'($random(seed)) | 1'($random(seed)), op, 4'($random(seed)), 4'($random(seed)),
        1'($random(seed)), 8'($random(seed)));
  endtask : rnd_cyc

  // -----------------------------------------------------------------------------
  // verdict, the only end of the run
  // -----------------------------------------------------------------------------
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  // -----------------------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------------------
  initial begin
    i_core_clk = 1'b0;
    i_nrst = 1'b0;
    {i_instr_valid, i_instr, i_acc, i_reg_b, i_timer_cnt_we, i_timer_cnt_wdata} = '0;
    num_errors = 0;
    n_compared = 0;
    seed = 32'h1c2c;
    ops = '{`T2RT_OP_LOAD_TIMER_AND_LOW_RELOAD, `T2RT_OP_LOAD_HIGH_RELOAD,
            `T2RT_OP_COPY_LOW_RELOAD_TO_TIMER, `T2RT_OP_COPY_B_TO_ACC};
    @(posedge i_core_clk);
    #1;
    // reset held 12 cycles while random traffic must be ignored
    repeat (12) rnd_cyc();
    $display("test reset done");
    i_nrst = 1'b1;
    // corners: back to back, conflicts with the external count write, near misses
    cyc(1'b1, ops[0], 4'h3, 4'h5, 1'b0, 8'h00);
    cyc(1'b1, ops[1], 4'hC, 4'hA, 1'b1, 8'h7F);
    cyc(1'b1, ops[0], 4'hF, 4'h0, 1'b1, 8'h11);
    cyc(1'b1, ops[2], 4'h1, 4'h2, 1'b1, 8'hEE);
    cyc(1'b1, ops[3], 4'h0, 4'h9, 1'b0, 8'h00);
    cyc(1'b1, ops[3], 4'h0, 4'h6, 1'b1, 8'h42);
    cyc(1'b0, ops[0], 4'h8, 4'h8, 1'b0, 8'h00);
    cyc(1'b1, 10'h230, 4'h8, 4'h8, 1'b0, 8'h00);
    cyc(1'b1, 10'h296, 4'h8, 4'h8, 1'b0, 8'h00);
    cyc(1'b1, 10'h11E, 4'h8, 4'h8, 1'b0, 8'h00);
    cyc(1'b1, ops[2], 4'h0, 4'h0, 1'b0, 8'h00);
    $display("test corners done");
    repeat (3000) rnd_cyc();
    $display("test random done");
    // second reset in mid-run, then traffic again
    i_nrst = 1'b0;
    repeat (2) rnd_cyc();
    i_nrst = 1'b1;
    repeat (500) rnd_cyc();
    $display("test mid reset done");
    report_and_stop();
  end
endmodule : tb

`default_nettype wire
